/* logic/mac_retry_backoff_padstrip.sv */
// MAC transmit retry with backoff, and receive pad and FCS stripping
//------------------------------------------------------------------
// What this block does
// RULE_01: Single attempt control set: exactly one transmit attempt per frame.
// RULE_02: Single attempt and collision: drop frame, go on, flag retry error.
// RULE_03: Otherwise retry up to 16 attempts, then flag retry error.
// RULE_04: Pad strip on: remove pad from frames with length field below 46.
// RULE_05: When pad is removed, the FCS is removed too.
// RULE_06: Pad strip on, length 46 or more: deliver unchanged with FCS.
// RULE_07: Pad strip off: deliver every frame unchanged.
// RULE_08: After collision wait r slot times, 0 <= r < 2^K.
// RULE_09: K is the smaller of the retry count and 10.
// RULE_10: Random value comes from a free running 20-bit LFSR.
// RULE_11: Load low K LFSR bits, count down per slot, retry at zero.
// RULE_12: Cap code 00 allows 10 bits, code 01 allows 8 bits.
// RULE_13: Cap code 10 allows 4 bits, code 11 allows 1 bit.
// RULE_14: One slot time is 512 bit times.
// RULE_15: Retry count clears when a new frame starts.
//------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "mac_retry_params.svh"
module mac_retry_backoff_padstrip import mac_retry_pkg::*; #(
	parameter int SLOT_CYC = `SLOT_CYCLES
) (
	input wire logic sys_clk, // System clock, 100 MHz
	input wire logic sys_rst, // Async reset, active high
	input wire logic single_attempt_ctl, // One attempt per frame
	input wire logic short_pad_strip_en, // Strip pad and FCS on short frames
	input wire logic [1:0] backoff_cap_sel, // LFSR bit cap code
	input wire logic tx_frame_req, // A queued frame is ready
	output logic tx_start, // Pulse: begin an attempt
	input wire logic tx_collision, // Pulse: collision on this attempt
	input wire logic tx_attempt_ok, // Pulse: attempt completed cleanly
	output logic tx_frame_done, // Pulse: frame retired, status valid
	output tx_status_t tx_status, // Status of retired frame
	output logic backoff_active, // Waiting out backoff
	input wire logic rx_in_valid, // Received byte valid
	input wire rx_beat_t rx_in, // Received byte and last flag
	output logic rx_out_valid, // Delivered byte valid
	output rx_beat_t rx_out // Delivered byte and last flag
);
	//------------------------------------------------------------------
	// Random source and slot timing
	//------------------------------------------------------------------
	logic [19:0] lfsr, next_lfsr;
	logic [15:0] slot_cnt, next_slot_cnt;
	logic slot_tick;
	// Free running; taps 20,17 give a maximal sequence
	always_comb begin
		next_lfsr = {lfsr[18:0], lfsr[19] ^ lfsr[16]}; // RULE_10
		slot_tick = (slot_cnt == 16'(SLOT_CYC - 1)); // RULE_14
		next_slot_cnt = slot_tick ? 16'h0000 : slot_cnt + 16'h0001;
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lfsr <= `LFSR_SEED;
			slot_cnt <= 16'h0000;
		end else begin
			lfsr <= next_lfsr;
			slot_cnt <= next_slot_cnt;
		end
	end

	//------------------------------------------------------------------
	// Transmit attempt and backoff control
	//------------------------------------------------------------------
	tx_state_t state, next_state;
	logic [4:0] retries, next_retries;
	logic [9:0] bo_cnt, next_bo_cnt;
	tx_status_t next_tx_status;
	logic next_done;
	logic [4:0] k_exp;
	logic [3:0] cap_bits;
	logic [9:0] bo_mask;
	// Exponent is retry count capped, then held to the cap field's bit count
	always_comb begin
		k_exp = (retries > `K_CAP) ? `K_CAP : retries; // RULE_09
		case (backoff_cap_sel)
			2'b00: cap_bits = 4'd10; // RULE_12
			2'b01: cap_bits = 4'd8; // RULE_12
			2'b10: cap_bits = 4'd4; // RULE_13
			2'b11: cap_bits = 4'd1; // RULE_13
			default: cap_bits = 4'd10;
		endcase
		if (k_exp[3:0] < cap_bits)
			bo_mask = 10'((11'h001 << k_exp) - 11'h001); // RULE_08
		else
			bo_mask = 10'((11'h001 << cap_bits) - 11'h001); // RULE_13
	end
	// A collision on the final attempt retires the frame with error
	always_comb begin
		next_state = state;
		next_retries = retries;
		next_bo_cnt = bo_cnt;
		next_tx_status = tx_status;
		next_done = 1'b0;
		tx_start = 1'b0;
		case (state)
			TX_IDLE: begin
				if (tx_frame_req) begin
					tx_start = 1'b1;
					next_retries = 5'd0; // RULE_15
					next_state = TX_SEND;
				end
			end
			TX_SEND: begin
				if (tx_attempt_ok) begin
					next_tx_status = '{retry_err: 1'b0,
						attempts: 5'(retries + 5'd1)};
					next_done = 1'b1;
					next_state = TX_DONE;
				end else if (tx_collision) begin
					if (single_attempt_ctl ||
						retries == `MAX_ATTEMPTS - 5'd1) begin
						// RULE_01 RULE_02 RULE_03
						next_tx_status = '{retry_err: 1'b1,
							attempts: 5'(retries + 5'd1)};
						next_done = 1'b1;
						next_state = TX_DONE;
					end else begin
						next_retries = retries + 5'd1;
						next_state = TX_BACKOFF;
					end
				end
			end
			TX_BACKOFF: begin
				if (bo_cnt == 10'h000) begin // RULE_11
					tx_start = 1'b1;
					next_state = TX_SEND;
				end else if (slot_tick) begin
					next_bo_cnt = bo_cnt - 10'h001; // RULE_11
				end
			end
			TX_DONE: next_state = TX_IDLE;
			default: next_state = TX_IDLE;
		endcase
		if (state == TX_SEND && next_state == TX_BACKOFF) begin
			// Exponent uses the count including this collision
			if (k_exp + 5'd1 > `K_CAP || k_exp[3:0] + 4'd1 > cap_bits)
				next_bo_cnt = lfsr[9:0] & bo_mask; // RULE_11
			else
				next_bo_cnt = lfsr[9:0] & {bo_mask[8:0], 1'b1};
		end
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= TX_IDLE;
			retries <= 5'd0;
			bo_cnt <= 10'h000;
			tx_status <= '0;
			tx_frame_done <= 1'b0;
		end else begin
			state <= next_state;
			retries <= next_retries;
			bo_cnt <= next_bo_cnt;
			tx_status <= next_tx_status;
			tx_frame_done <= next_done;
		end
	end
	assign backoff_active = (state == TX_BACKOFF);

	//------------------------------------------------------------------
	// Receive pad and FCS strip
	//------------------------------------------------------------------
	logic [15:0] rx_idx, next_rx_idx;
	logic [15:0] len_fld, next_len_fld;
	logic strip, next_strip;
	logic next_out_valid;
	rx_beat_t next_out;
	logic in_data;
	logic keep;
	// Length field sits in bytes 12 and 13; bytes after data are dropped.
	// The last byte of a stripped frame carries last even if dropped is
	// its pad, so the final kept byte is marked at the cut point.
	always_comb begin
		next_rx_idx = rx_idx;
		next_len_fld = len_fld;
		next_strip = strip;
		next_out_valid = 1'b0;
		next_out = rx_out;
		in_data = 1'b0;
		keep = 1'b1;
		if (rx_in_valid) begin
			next_rx_idx = rx_in.last ? 16'h0000 : rx_idx + 16'h0001;
			if (rx_idx == 16'd12)
				next_len_fld = {rx_in.data, len_fld[7:0]};
			if (rx_idx == 16'd13) begin
				next_len_fld = {len_fld[15:8], rx_in.data};
				// RULE_04 RULE_06 RULE_07
				next_strip = short_pad_strip_en &&
					({len_fld[15:8], rx_in.data} < `PAD_MIN_LEN);
			end
			in_data = rx_idx < 16'(`HDR_BYTES) + len_fld;
			// Pad and FCS go together once the cut is made
			if (strip && rx_idx >= 16'd14 && !in_data)
				keep = 1'b0; // RULE_05
			if (keep) begin
				next_out_valid = 1'b1;
				next_out.data = rx_in.data;
				// At byte 13 the cut is decided in this very cycle, so the
				// fresh decision and length are used, or a zero length
				// frame would lose its end mark
				next_out.last = rx_in.last || (next_strip &&
					rx_idx >= 16'd13 &&
					rx_idx + 16'h0001 == 16'(`HDR_BYTES) + next_len_fld);
			end
			if (rx_in.last)
				next_strip = 1'b0;
		end
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_idx <= 16'h0000;
			len_fld <= 16'hffff;
			strip <= 1'b0;
			rx_out_valid <= 1'b0;
			rx_out <= '0;
		end else begin
			rx_idx <= next_rx_idx;
			len_fld <= next_len_fld;
			strip <= next_strip;
			rx_out_valid <= next_out_valid;
			rx_out <= next_out;
		end
	end

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	sequence coll_in_send;
		state == TX_SEND && tx_collision && !tx_attempt_ok;
	endsequence
	single_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		coll_in_send and single_attempt_ctl |=> tx_frame_done
		&& tx_status.retry_err) // RULE_02
		else $error("single attempt collision not retired with error");
	single_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		single_attempt_ctl && tx_frame_done |-> tx_status.attempts == 5'd1)
		// RULE_01
		else $error("more than one attempt in single attempt mode");
	attempt_cap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		tx_frame_done && tx_status.retry_err && !$past(single_attempt_ctl)
		|-> tx_status.attempts == 5'd16) // RULE_03
		else $error("retry error before sixteen attempts");
	retry_back_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		coll_in_send and !single_attempt_ctl and retries < 5'd15
		|=> backoff_active) // RULE_08
		else $error("collision did not enter backoff");
	bo_bound_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(backoff_active) |-> bo_cnt < (11'h001 << cap_bits)) // RULE_13
		else $error("backoff count over cap");
	k_cap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		k_exp <= `K_CAP && k_exp <= retries) // RULE_09
		else $error("exponent above limit");
	bo_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		backoff_active && bo_cnt == 10'h000 |-> tx_start) // RULE_11
		else $error("no retry at backoff zero");
	new_frame_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state == TX_IDLE && tx_frame_req |=> retries == 5'd0) // RULE_15
		else $error("retry count not cleared");
	slot_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		slot_tick |=> !slot_tick && slot_cnt == 16'h0000) // RULE_14
		else $error("slot tick spacing wrong");
	lfsr_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst |=> lfsr != 20'h00000 && lfsr == $past(next_lfsr)) // RULE_10
		else $error("lfsr stalled");
	no_strip_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rx_in_valid && !short_pad_strip_en && !strip |=> rx_out_valid
		&& rx_out.data == $past(rx_in.data)) // RULE_07
		else $error("frame modified with strip off");
	// Backoff count starts inside the window of the current exponent
	bo_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(backoff_active) |-> (bo_cnt & ~bo_mask) == 10'h000) // RULE_08
		else $error("backoff count outside exponent window");
	// The count moves only on a slot boundary and by exactly one
	sequence bo_waiting;
		backoff_active && bo_cnt != 10'h000;
	endsequence
	bo_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bo_waiting and slot_tick |=> bo_cnt == $past(bo_cnt) - 10'h001)
		// RULE_11
		else $error("backoff count did not step on slot");
	bo_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bo_waiting and !slot_tick |=> backoff_active && $stable(bo_cnt))
		// RULE_11
		else $error("backoff count moved between slots");
	slot_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		slot_cnt <= 16'(SLOT_CYC - 1)) // RULE_14
		else $error("slot counter past its end");
	// Once cut, nothing past the data field comes out
	pad_cut_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rx_in_valid && strip && rx_idx >= 16'd14 && !in_data
		|=> !rx_out_valid) // RULE_05
		else $error("pad or FCS byte delivered");
	// Without a cut every byte passes through exactly as it came
	long_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rx_in_valid && !strip && rx_idx != 16'd13
		|=> rx_out_valid && rx_out == $past(rx_in)) // RULE_06
		else $error("uncut frame modified");
	done_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		tx_frame_done |=> !tx_frame_done && !backoff_active) // RULE_02
		else $error("frame retire pulse too long");
endmodule
`default_nettype wire

/* logic/mac_retry_params.svh */
// Constants for the MAC retry, backoff and receive pad strip block
`ifndef MAC_RETRY_PARAMS_SVH
`define MAC_RETRY_PARAMS_SVH
`define MAX_ATTEMPTS 5'd16
`define K_CAP 5'd10
`define PAD_MIN_LEN 16'd46
`define SLOT_BITS 512
`define BIT_NS_100M 10
`define CLK_NS 10
`define SLOT_NS (`SLOT_BITS * `BIT_NS_100M)
`define SLOT_CYCLES (`SLOT_NS / `CLK_NS)
`define LFSR_SEED 20'h00001
`define FCS_BYTES 4
`define HDR_BYTES 14
`endif

/* logic/mac_retry_pkg.sv */
// Types shared by the MAC retry, backoff and receive pad strip block
package mac_retry_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} rx_beat_t;
	typedef struct packed {
		logic retry_err;
		logic [4:0] attempts;
	} tx_status_t;
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_SEND = 4'b0010,
		TX_BACKOFF = 4'b0100,
		TX_DONE = 4'b1000
	} tx_state_t;
endpackage

/* verification/mac_medium_model.sv */
// Behavioural model of the PHY and shared medium seen by the MAC
`timescale 1ns/1ps
`default_nettype none
module mac_medium_model (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Async reset, active high
	input wire logic tx_start, // Attempt begins
	input wire logic tx_frame_done, // Frame retired
	input wire logic [4:0] n_coll, // Collisions before success
	input wire logic [2:0] lag, // Answer delay in cycles
	output logic tx_collision, // Pulse: attempt collided
	output logic tx_attempt_ok // Pulse: attempt went out
);
	logic busy;
	logic [4:0] seen;
	logic [2:0] cnt;
	// ----
	// Answer each attempt after lag cycles
	// ----
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy <= 1'h0;
			seen <= 5'h0;
			cnt <= 3'h0;
			tx_collision <= 1'h0;
			tx_attempt_ok <= 1'h0;
		end else begin
			tx_collision <= 1'h0;
			tx_attempt_ok <= 1'h0;
			// Collision tally is per frame, so clear it on retire
			if (tx_frame_done) seen <= 5'h0;
			if (tx_start && !busy) begin
				busy <= 1'h1;
				cnt <= lag;
			end else if (busy && cnt != 3'h0) begin
				cnt <= cnt - 3'h1;
			end else if (busy) begin
				busy <= 1'h0;
				if (seen < n_coll) begin
					tx_collision <= 1'h1;
					seen <= seen + 5'h1;
				end else begin
					tx_attempt_ok <= 1'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Self-checking testbench for the MAC retry, backoff and pad strip block
`timescale 1ns/1ps
`default_nettype none
module tb import mac_retry_pkg::*;;
	localparam int SC = 8; // Short slot keeps the run brief
	logic sys_clk = 1'h0, sys_rst = 1'h1, sa = 1'h0, strip = 1'h0;
	logic req = 1'h0, rv = 1'h0;
	logic [1:0] cap = 2'h0;
	logic [4:0] nc = 5'h0;
	logic [2:0] lag = 3'h0;
	rx_beat_t ri = '0;
	logic ts, col, ok, done, bo, ov;
	tx_status_t st;
	rx_beat_t ro;
	rx_beat_t got[$];
	int n_fail = 0, cmp_count = 0, seed = 45;
	mac_retry_backoff_padstrip #(.SLOT_CYC(SC)) u_mac_retry_backoff_padstrip (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .single_attempt_ctl(sa),
		.short_pad_strip_en(strip), .backoff_cap_sel(cap),
		.tx_frame_req(req), .tx_start(ts), .tx_collision(col),
		.tx_attempt_ok(ok), .tx_frame_done(done), .tx_status(st),
		.backoff_active(bo), .rx_in_valid(rv), .rx_in(ri),
		.rx_out_valid(ov), .rx_out(ro));
	mac_medium_model u_mac_medium_model (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .tx_start(ts), .tx_frame_done(done),
		.n_coll(nc), .lag(lag), .tx_collision(col), .tx_attempt_ok(ok));
	// Clock and delivered-byte capture
	initial forever #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (ov === 1'h1) got.push_back(ro);
	// ----
	// Checking and expectations
	// ----
	task automatic conclude();
		$display("fails %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, e, input string m);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic chk_le(input int g, lim, input string m);
		cmp_count++;
		if (g > lim) begin
			n_fail++;
			$display("BAD %0t %s %0d over %0d", $time, m, g, lim);
		end
	endtask
	// Status {retry_err, attempts} that a frame must retire with
	function automatic logic [5:0] exp_st(logic s, logic [4:0] n);
		if (s) return {n != 5'h0, 5'h1};
		if (n >= 5'h10) return {1'h1, 5'h10};
		return {1'h0, n + 5'h1};
	endfunction
	function automatic int cap_bits(logic [1:0] c);
		return c == 2'h0 ? 10 : c == 2'h1 ? 8 : c == 2'h2 ? 4 : 1;
	endfunction
	// ----
	// Transmit one frame against n collisions
	// ----
	task automatic tx_frame(input logic s, input logic [1:0] c,
		input logic [4:0] n);
		int cyc, starts, colls, run, k;
		logic [5:0] e;
		starts = 0;
		colls = 0;
		run = 0;
		e = exp_st(s, n);
		@(posedge sys_clk);
		sa <= s;
		cap <= c;
		nc <= n;
		lag <= 3'($random(seed));
		req <= 1'h1;
		for (cyc = 0; cyc < 20000; cyc++) begin
			@(negedge sys_clk);
			if (ts === 1'h1) starts++;
			if (col === 1'h1) colls++;
			if (bo === 1'h1) run++;
			else if (run > 0) begin
				k = colls < cap_bits(c) ? colls : cap_bits(c);
				if (k > 10) k = 10;
				chk_le(run, (1 << k) * SC + 4, "backoff");
				run = 0;
			end
			if (done === 1'h1) break;
			@(posedge sys_clk);
			if (starts > 0) req <= 1'h0;
		end
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
		chk({10'h0, st}, {10'h0, e}, "status");
		chk(16'(starts), {11'h0, e[4:0]}, "attempts");
		$display("tx test done sa %0d cap %0d coll %0d", s, c, n);
		repeat (2) @(posedge sys_clk);
	endtask
	// ----
	// Receive one frame with a given length field
	// ----
	task automatic rx_frame(input logic s, input int len);
		int tot, keep, i;
		logic [7:0] b;
		logic [7:0] fb[$];
		tot = (len < 46) ? 64 : len + 18;
		keep = (s && len < 46) ? len + 14 : tot;
		got.delete();
		@(posedge sys_clk);
		strip <= s;
		for (i = 0; i < tot; i++) begin
			b = i == 12 ? 8'(len >> 8) : i == 13 ? 8'(len) : 8'($random(seed));
			fb.push_back(b);
			@(posedge sys_clk);
			rv <= 1'h1;
			ri <= '{data: b, last: 1'(i == tot - 1)};
		end
		@(posedge sys_clk);
		rv <= 1'h0;
		repeat (3) @(posedge sys_clk);
		chk(16'(got.size()), 16'(keep), "rx count");
		for (i = 0; i < keep && i < got.size(); i++)
			chk({7'h0, got[i]}, {7'h0, fb[i], 1'(i == keep - 1)},
				"rx");
		$display("rx test done strip %0d len %0d", s, len);
	endtask
	// Main sequence: transmit corners then random frames, then receive corners then random frames
	initial begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'h0;
		tx_frame(1'h1, 2'h0, 5'h1);
		tx_frame(1'h1, 2'h0, 5'h0);
		tx_frame(1'h0, 2'h3, 5'h10);
		for (int c = 0; c < 4; c++) tx_frame(1'h0, 2'(c), 5'h4);
		repeat (6) tx_frame(1'h0, 2'($random(seed)),
			5'($random(seed)) % 5'h6);
		for (int s = 0; s < 2; s++) begin
			rx_frame(1'(s), 45);
			rx_frame(1'(s), 46);
			rx_frame(1'(s), 0);
		end
		repeat (8) rx_frame(1'($random(seed)), {$random(seed)} % 80);
		conclude();
	end
endmodule
`default_nettype wire
